// ### design/sid_consts.svh
`ifndef SID_CONSTS_SVH
`define SID_CONSTS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SID_CLK_HZ          20000000
`define SID_FLASH_HALF_MS   500
`define SID_FLASH_HALF_CYC  (`SID_FLASH_HALF_MS * (`SID_CLK_HZ / 1000))

// ----------------------------------------------------------------------
// Register map (byte addresses, one word each)
// ----------------------------------------------------------------------
`define SID_ADDR_W          4
`define SID_OFS_CTRL        4'h0
`define SID_OFS_LAMPS       4'h4
`define SID_OFS_STATUS      4'h8
`define SID_OFS_MASK        4'hc

// Control fields and reset value
`define SID_CTRL_W          2
`define SID_CTRL_EN_BIT     0
`define SID_CTRL_TEST_BIT   1
`define SID_CTRL_RESET      2'h1

// Event bits of status and mask
`define SID_N_EVT           4
`define SID_EVT_RUN         0
`define SID_EVT_FAULT       1
`define SID_EVT_CELL        2
`define SID_EVT_CARD        3

// ----------------------------------------------------------------------
// Lamp indices
// ----------------------------------------------------------------------
`define SID_N_LAMP          9
`define SID_LAMP_W          2
`define SID_L_RUN           0
`define SID_L_OVR           1
`define SID_L_CELL          2
`define SID_L_IO            3
`define SID_L_CARD          4
`define SID_L_DSER          5
`define SID_L_SER0          6
`define SID_L_SER1          7
`define SID_L_MOD           8

`endif

// ### design/sid_pkg.sv
`include "sid_consts.svh"

package sid_pkg;

  // Colour shown by a lamp
  typedef enum logic [1:0] {COL_OFF, COL_GREEN, COL_RED, COL_AMBER} sid_col_e;

  // Pattern chosen for a lamp
  typedef enum logic [1:0] {PAT_OFF, PAT_STEADY, PAT_FLASH, PAT_ALT} sid_pat_e;

  typedef struct packed {
    sid_col_e col;
    sid_pat_e pat;
  } sid_sel_s;

  // Whole state of the top module
  typedef struct packed {
    logic [`SID_CTRL_W-1:0]                ctrl;
    logic [`SID_N_EVT-1:0]                 mask;
    logic [`SID_N_EVT-1:0]                 status;
    logic [`SID_N_EVT-1:0]                 snap;
    logic                                  bus_wait;
    logic [31:0]                           rdata;
    logic                                  irq;
    logic                                  run_prev;
    logic                                  fault_prev;
    logic                                  cell_prev;
    logic                                  card_prev;
    sid_col_e [`SID_N_LAMP-1:0]            lamp;
  } sid_top_s;

endpackage : sid_pkg

// ### design/sid_blink.sv
`timescale 1ns/1ps
`default_nettype none
`include "sid_consts.svh"

module sid_blink #(
  parameter int unsigned HALF_CYC = `SID_FLASH_HALF_CYC
) (
  input  wire logic i_mclk,
  input  wire logic i_reset,
  output logic      o_phase
);

  localparam int CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          phase;
  } sid_blink_s;

  sid_blink_s st_q;
  sid_blink_s st_d;

  // Refuse a divider too short to give a visible toggle
  if (HALF_CYC < 2) begin : g_chk
    $error("sid_blink: HALF_CYC must be at least 2");
  end

  // ------------------------------------------------------------------
  // Shared divider
  // ------------------------------------------------------------------
  // One phase for every lamp, so all lamps on PAT_FLASH stay in step
  always_comb begin
    st_d = st_q;
    if (st_q.cnt == LAST) begin
      st_d.cnt   = '0;
      st_d.phase = ~st_q.phase;
    end else begin
      st_d.cnt = st_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_phase = st_q.phase;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  phase_only_wrap_a: assert property ($changed(o_phase) |-> $past(st_q.cnt) == LAST)
    else $error("phase toggled before the divider wrapped");
  phase_on_wrap_a: assert property ((st_q.cnt == LAST) |=> $changed(o_phase))
    else $error("divider wrapped without a phase toggle");

endmodule : sid_blink

`default_nettype wire

// ### design/sid_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sid_consts.svh"

module sid_top #(
  parameter int unsigned FLASH_HALF_CYC = `SID_FLASH_HALF_CYC,
  parameter bit          HAS_SERIAL_ONE = 1'b1
) (
  input  wire logic                   i_mclk,
  input  wire logic                   i_reset,
  // Controller state, same clock
  input  wire logic                   i_run_mode,
  input  wire logic                   i_force_enabled,
  input  wire logic                   i_force_values_exist,
  input  wire logic                   i_cell_absent,
  input  wire logic                   i_cell_discharged,
  input  wire logic                   i_io_none_configured,
  input  wire logic                   i_project_loaded,
  input  wire logic                   i_io_all_ok,
  input  wire logic                   i_io_some_missing,
  input  wire logic                   i_io_none_respond,
  input  wire logic                   i_faulted,
  input  wire logic                   i_card_busy,
  input  wire logic                   i_card_bad_fs,
  input  wire logic                   i_serial0_default,
  input  wire logic                   i_serial0_active,
  input  wire logic                   i_serial1_active,
  input  wire logic                   i_net_started,
  input  wire logic                   i_net_connected,
  // Avalon-MM slave
  input  wire logic [`SID_ADDR_W-1:0] i_address,
  input  wire logic                   i_read,
  input  wire logic                   i_write,
  input  wire logic [31:0]            i_writedata,
  input  wire logic [3:0]             i_byteenable,
  output logic      [31:0]            o_readdata,
  output logic                        o_waitrequest,
  output logic                        o_irq,
  // Lamps
  output sid_pkg::sid_col_e           o_run_lamp,
  output sid_pkg::sid_col_e           o_override_lamp,
  output sid_pkg::sid_col_e           o_backup_cell_lamp,
  output sid_pkg::sid_col_e           o_io_lamp,
  output sid_pkg::sid_col_e           o_card_activity_lamp,
  output sid_pkg::sid_col_e           o_default_serial_setting_lamp,
  output sid_pkg::sid_col_e           o_serial_zero_activity_lamp,
  output sid_pkg::sid_col_e           o_serial_one_activity_lamp,
  output sid_pkg::sid_col_e           o_module_state_lamp
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  sid_pkg::sid_top_s                   st_q;
  sid_pkg::sid_top_s                   st_d;
  sid_pkg::sid_sel_s [`SID_N_LAMP-1:0] sel;
  logic [`SID_N_EVT-1:0]               evt;
  logic [`SID_N_EVT-1:0]               clr;
  logic                                phase;
  logic                                cell_low;
  logic                                lamp_on;
  logic                                lamp_test;

  // ------------------------------------------------------------------
  // Shared blink phase
  // ------------------------------------------------------------------
  sid_blink #(
    .HALF_CYC (FLASH_HALF_CYC)
  ) u_blink (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .o_phase (phase)
  );

  assign lamp_on   = st_q.ctrl[`SID_CTRL_EN_BIT];
  assign lamp_test = st_q.ctrl[`SID_CTRL_TEST_BIT];
  assign cell_low  = i_cell_absent | i_cell_discharged;

  // ------------------------------------------------------------------
  // Lamp selection
  // ------------------------------------------------------------------
  // Each lamp picks a colour and a pattern from the controller state
  always_comb begin
    sel = '0;

    // Run lamp
    if (i_run_mode) begin
      sel[`SID_L_RUN] = '{sid_pkg::COL_GREEN, sid_pkg::PAT_STEADY};
    end

    // Override lamp: enabled beats pending values
    if (i_force_enabled) begin
      sel[`SID_L_OVR] = '{sid_pkg::COL_AMBER, sid_pkg::PAT_STEADY};
    end else if (i_force_values_exist) begin
      sel[`SID_L_OVR] = '{sid_pkg::COL_AMBER, sid_pkg::PAT_FLASH};
    end else begin
      sel[`SID_L_OVR] = '{sid_pkg::COL_OFF, sid_pkg::PAT_OFF};
    end

    // Backup cell lamp
    if (cell_low) begin
      sel[`SID_L_CELL] = '{sid_pkg::COL_RED, sid_pkg::PAT_STEADY};
    end

    // I/O lamp: nothing to show outranks every other state
    if (i_io_none_configured || !i_project_loaded) begin
      sel[`SID_L_IO] = '{sid_pkg::COL_OFF, sid_pkg::PAT_OFF};
    end else if (i_faulted || i_io_none_respond) begin
      sel[`SID_L_IO] = '{sid_pkg::COL_RED, sid_pkg::PAT_FLASH};
    end else if (i_io_some_missing) begin
      sel[`SID_L_IO] = '{sid_pkg::COL_GREEN, sid_pkg::PAT_FLASH};
    end else if (i_io_all_ok) begin
      sel[`SID_L_IO] = '{sid_pkg::COL_GREEN, sid_pkg::PAT_STEADY};
    end

    // Card lamp: a broken card is reported over activity
    if (i_card_bad_fs) begin
      sel[`SID_L_CARD] = '{sid_pkg::COL_RED, sid_pkg::PAT_FLASH};
    end else if (i_card_busy) begin
      sel[`SID_L_CARD] = '{sid_pkg::COL_GREEN, sid_pkg::PAT_FLASH};
    end

    // Serial lamps
    if (i_serial0_default) begin
      sel[`SID_L_DSER] = '{sid_pkg::COL_GREEN, sid_pkg::PAT_STEADY};
    end
    if (i_serial0_active) begin
      sel[`SID_L_SER0] = '{sid_pkg::COL_GREEN, sid_pkg::PAT_FLASH};
    end
    // Variant without the second channel keeps its lamp dark outside lamp test
    if (HAS_SERIAL_ONE && i_serial1_active) begin
      sel[`SID_L_SER1] = '{sid_pkg::COL_GREEN, sid_pkg::PAT_FLASH};
    end

    // Module state lamp: local messaging counts even when detached
    if (i_net_started && i_net_connected) begin
      sel[`SID_L_MOD] = '{sid_pkg::COL_GREEN, sid_pkg::PAT_STEADY};
    end else if (i_net_started) begin
      sel[`SID_L_MOD] = '{sid_pkg::COL_GREEN, sid_pkg::PAT_FLASH};
    end
  end

  // ------------------------------------------------------------------
  // Events for the interrupt status
  // ------------------------------------------------------------------
  always_comb begin
    evt                 = '0;
    evt[`SID_EVT_RUN]   = i_run_mode ^ st_q.run_prev;
    evt[`SID_EVT_FAULT] = i_faulted & ~st_q.fault_prev;
    evt[`SID_EVT_CELL]  = cell_low & ~st_q.cell_prev;
    evt[`SID_EVT_CARD]  = i_card_bad_fs & ~st_q.card_prev;
  end

  // ------------------------------------------------------------------
  // Next state: lamps and bus slave
  // ------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    clr  = '0;

    st_d.run_prev   = i_run_mode;
    st_d.fault_prev = i_faulted;
    st_d.cell_prev  = cell_low;
    st_d.card_prev  = i_card_bad_fs;

    // Pattern resolution; the blink phase is the only time base
    for (int i = 0; i < `SID_N_LAMP; i++) begin
      if (!lamp_on) begin
        st_d.lamp[i] = sid_pkg::COL_OFF;
      end else if (lamp_test) begin
        // Neighbours alternate, which exercises every neighbouring lamp pair
        st_d.lamp[i] = (phase ^ (i % 2 == 1)) ? sid_pkg::COL_GREEN
                                              : sid_pkg::COL_OFF;
      end else begin
        case (sel[i].pat)
          sid_pkg::PAT_STEADY: st_d.lamp[i] = sel[i].col;
          sid_pkg::PAT_FLASH:  st_d.lamp[i] = phase ? sel[i].col
                                                    : sid_pkg::COL_OFF;
          sid_pkg::PAT_ALT:    st_d.lamp[i] = (phase ^ (i % 2 == 1))
                                            ? sel[i].col : sid_pkg::COL_OFF;
          default:             st_d.lamp[i] = sid_pkg::COL_OFF;
        endcase
      end
    end

    // First cycle of a request: load read data, drop waitrequest
    if ((i_read || i_write) && st_q.bus_wait) begin
      st_d.bus_wait = 1'b0;
      st_d.rdata    = '0;
      st_d.snap     = '0;
      if (i_read) begin
        case (i_address)
          `SID_OFS_CTRL:   st_d.rdata[`SID_CTRL_W-1:0] = st_q.ctrl;
          `SID_OFS_LAMPS:  st_d.rdata[`SID_N_LAMP*`SID_LAMP_W-1:0] = st_q.lamp;
          `SID_OFS_STATUS: begin
            st_d.rdata[`SID_N_EVT-1:0] = st_q.status;
            st_d.snap                  = st_q.status;
          end
          `SID_OFS_MASK:   st_d.rdata[`SID_N_EVT-1:0] = st_q.mask;
          default:         st_d.rdata = '0;
        endcase
      end
    end else if ((i_read || i_write) && !st_q.bus_wait) begin
      // Accepting edge: writes land, status read clears what it returned
      st_d.bus_wait = 1'b1;
      if (i_write && i_byteenable[0]) begin
        case (i_address)
          `SID_OFS_CTRL: st_d.ctrl = i_writedata[`SID_CTRL_W-1:0];
          `SID_OFS_MASK: st_d.mask = i_writedata[`SID_N_EVT-1:0];
          default:       st_d.ctrl = st_q.ctrl;
        endcase
      end
      if (i_read && i_address == `SID_OFS_STATUS) begin
        clr = st_q.snap;
      end
    end

    // Only the returned bits clear, and a new event wins over the clear
    st_d.status = (st_q.status & ~clr) | evt;
    st_d.irq    = |(st_d.status & st_d.mask);
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      st_q          <= '0;
      st_q.ctrl     <= `SID_CTRL_RESET;
      st_q.bus_wait <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Every output is a field of the state register
  assign o_readdata                    = st_q.rdata;
  assign o_waitrequest                 = st_q.bus_wait;
  assign o_irq                         = st_q.irq;
  assign o_run_lamp                    = st_q.lamp[`SID_L_RUN];
  assign o_override_lamp               = st_q.lamp[`SID_L_OVR];
  assign o_backup_cell_lamp            = st_q.lamp[`SID_L_CELL];
  assign o_io_lamp                     = st_q.lamp[`SID_L_IO];
  assign o_card_activity_lamp          = st_q.lamp[`SID_L_CARD];
  assign o_default_serial_setting_lamp = st_q.lamp[`SID_L_DSER];
  assign o_serial_zero_activity_lamp   = st_q.lamp[`SID_L_SER0];
  assign o_serial_one_activity_lamp    = st_q.lamp[`SID_L_SER1];
  assign o_module_state_lamp           = st_q.lamp[`SID_L_MOD];

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  logic normal;
  assign normal = lamp_on && !lamp_test;

  run_lamp_mode_a: assert property (normal |=> o_run_lamp ==
      ($past(i_run_mode) ? sid_pkg::COL_GREEN : sid_pkg::COL_OFF))
    else $error("run lamp does not follow run mode");

  override_dark_a: assert property (normal && !i_force_enabled &&
      !i_force_values_exist |=> o_override_lamp == sid_pkg::COL_OFF)
    else $error("override lamp lit with nothing to show");

  override_steady_a: assert property (normal && i_force_enabled
      |=> o_override_lamp == sid_pkg::COL_AMBER)
    else $error("override lamp not steady amber while enabled");

  override_flash_a: assert property (normal && !i_force_enabled &&
      i_force_values_exist |=> o_override_lamp ==
      ($past(phase) ? sid_pkg::COL_AMBER : sid_pkg::COL_OFF))
    else $error("override lamp not flashing amber");

  cell_lamp_a: assert property (normal |=> o_backup_cell_lamp ==
      ($past(cell_low) ? sid_pkg::COL_RED : sid_pkg::COL_OFF))
    else $error("backup cell lamp wrong");

  io_dark_a: assert property (normal && (i_io_none_configured ||
      !i_project_loaded) |=> o_io_lamp == sid_pkg::COL_OFF)
    else $error("io lamp lit without devices or project");

  io_green_a: assert property (normal && i_project_loaded && !i_io_none_configured &&
      !i_faulted && !i_io_none_respond && !i_io_some_missing && i_io_all_ok
      |=> o_io_lamp == sid_pkg::COL_GREEN)
    else $error("io lamp not steady green with all devices up");

  io_miss_flash_a: assert property (normal && i_project_loaded &&
      !i_io_none_configured && !i_faulted && !i_io_none_respond &&
      i_io_some_missing |=> o_io_lamp ==
      ($past(phase) ? sid_pkg::COL_GREEN : sid_pkg::COL_OFF))
    else $error("io lamp not flashing green with a device missing");

  io_red_flash_a: assert property (normal && i_project_loaded &&
      !i_io_none_configured && (i_faulted || i_io_none_respond)
      |=> o_io_lamp == ($past(phase) ? sid_pkg::COL_RED : sid_pkg::COL_OFF))
    else $error("io lamp not flashing red");

  card_lamp_a: assert property (normal && !i_card_bad_fs |=>
      o_card_activity_lamp == (($past(i_card_busy) && $past(phase))
      ? sid_pkg::COL_GREEN : sid_pkg::COL_OFF))
    else $error("card lamp does not follow card activity");

  card_bad_a: assert property (normal && i_card_bad_fs && phase
      |=> o_card_activity_lamp == sid_pkg::COL_RED)
    else $error("card lamp not red on bad file system");

  default_serial_a: assert property (normal |=> o_default_serial_setting_lamp
      == ($past(i_serial0_default) ? sid_pkg::COL_GREEN : sid_pkg::COL_OFF))
    else $error("default serial lamp wrong");

  serial_zero_a: assert property (normal && !i_serial0_active
      |=> o_serial_zero_activity_lamp == sid_pkg::COL_OFF)
    else $error("serial lamp lit without traffic");

  steady_hold_a: assert property ((normal && i_run_mode) [*2]
      |-> (o_run_lamp == sid_pkg::COL_GREEN) [*2])
    else $error("steady lamp did not hold");

  alt_pair_a: assert property (lamp_on && lamp_test |=>
      (o_run_lamp == sid_pkg::COL_OFF) != (o_override_lamp == sid_pkg::COL_OFF))
    else $error("alternating pair not in opposite states");

  flash_in_phase_a: assert property (normal && i_serial0_active &&
      i_card_busy && !i_card_bad_fs |=>
      (o_card_activity_lamp == sid_pkg::COL_OFF) ==
      (o_serial_zero_activity_lamp == sid_pkg::COL_OFF))
    else $error("flashing lamps out of phase");

  module_flash_a: assert property (normal && i_net_started &&
      !i_net_connected |=> o_module_state_lamp ==
      ($past(phase) ? sid_pkg::COL_GREEN : sid_pkg::COL_OFF))
    else $error("module lamp not flashing green when started");

  module_steady_a: assert property (normal && i_net_started &&
      i_net_connected |=> o_module_state_lamp == sid_pkg::COL_GREEN)
    else $error("module lamp not steady green with connections");

  status_sticky_a: assert property (st_q.status[`SID_EVT_FAULT] &&
      !(i_read && !o_waitrequest && i_address == `SID_OFS_STATUS)
      |=> st_q.status[`SID_EVT_FAULT])
    else $error("status bit dropped without a status read");

endmodule : sid_top

`default_nettype wire

// ### dv/sid_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
// Operator view of one chosen lamp: counts cycles in the wanted colour, dark or other
module sid_panel_model (
  input  wire logic        i_mclk,
  input  wire logic        i_clr,
  input  wire logic [3:0]  i_sel,
  input  wire logic [1:0]  i_want,
  input  wire logic [17:0] i_lamps,
  output logic      [7:0]  o_on,
  output logic      [7:0]  o_off,
  output logic      [7:0]  o_bad
);
  logic [1:0] col;
  assign col = i_lamps[2*i_sel+:2];
  // No saturation: viewing windows stay far below 255 cycles
  always_ff @(posedge i_mclk) begin
    o_on  <= i_clr ? 8'h00 : o_on + 8'(col == i_want);
    o_off <= i_clr ? 8'h00 : o_off + 8'(col != i_want && col == 2'h0);
    o_bad <= i_clr ? 8'h00 : o_bad + 8'(col != i_want && col != 2'h0);
  end
endmodule : sid_panel_model
`default_nettype wire

// ### dv/sid_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sid_top_tb_top;
  logic        clk, rst, clr, rd, wr, wreq, irq;
  logic [17:0] inp, lv;
  logic [3:0]  adr, sel;
  logic [31:0] wd, rdat, q;
  logic [1:0]  want;
  logic [7:0]  n_on, n_off, n_bad;
  int          n_mismatch, num_checks;
  sid_top #(.FLASH_HALF_CYC(4)) i_dut (
    .i_mclk(clk), .i_reset(rst), .i_run_mode(inp[0]), .i_force_enabled(inp[1]),
    .i_force_values_exist(inp[2]), .i_cell_absent(inp[3]), .i_cell_discharged(inp[4]),
    .i_io_none_configured(inp[5]), .i_project_loaded(inp[6]), .i_io_all_ok(inp[7]),
    .i_io_some_missing(inp[8]), .i_io_none_respond(inp[9]), .i_faulted(inp[10]),
    .i_card_busy(inp[11]), .i_card_bad_fs(inp[12]), .i_serial0_default(inp[13]),
    .i_serial0_active(inp[14]), .i_serial1_active(inp[15]), .i_net_started(inp[16]),
    .i_net_connected(inp[17]), .i_address(adr), .i_read(rd), .i_write(wr),
    .i_writedata(wd), .i_byteenable(4'h1), .o_readdata(rdat), .o_waitrequest(wreq),
    .o_irq(irq), .o_run_lamp(lv[1:0]), .o_override_lamp(lv[3:2]),
    .o_backup_cell_lamp(lv[5:4]), .o_io_lamp(lv[7:6]), .o_card_activity_lamp(lv[9:8]),
    .o_default_serial_setting_lamp(lv[11:10]), .o_serial_zero_activity_lamp(lv[13:12]),
    .o_serial_one_activity_lamp(lv[15:14]), .o_module_state_lamp(lv[17:16]));
  sid_panel_model i_panel (.i_mclk(clk), .i_clr(clr), .i_sel(sel), .i_want(want),
    .i_lamps(lv), .o_on(n_on), .o_off(n_off), .o_bad(n_bad));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Avalon access: request held until waitrequest is sampled low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wr  <= w;
    rd  <= !w;
    wd  <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) chk(n, 0);
  endtask : bus
  // Colours: 1 green, 2 red, 3 amber; window of 16 cycles spans two flash periods
  task lampt(input logic [17:0] v, input logic [3:0] i, input logic [1:0] c, input bit fl);
    @(posedge clk);
    inp  <= v;
    sel  <= i;
    want <= c;
    clr  <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    chk(n_bad == 0 && n_on != 0 && (fl ? n_off != 0 : n_off == 0), 1);
  endtask : lampt
  // Lit state of lamps a and b compared each cycle: equal in phase, opposite when alternating
  task pair(input logic [3:0] a, input logic [3:0] b, input bit alt);
    int bad;
    bad = 0;
    repeat (16) begin
      @(negedge clk);
      if (((lv[2*a+:2] != 2'h0) == (lv[2*b+:2] != 2'h0)) == alt) bad++;
    end
    chk(bad, 0);
  endtask : pair
  // Interrupt: clear stale events, unmask run change, raise, read-clear, masked event
  task irq_scn;
    bus(0, 4'h8, 0, q);
    bus(1, 4'hc, 1, q);
    // Look one edge after the mask write, once irq has settled
    @(posedge clk);
    chk(irq, 0);
    inp <= 18'h1;
    repeat (4) @(posedge clk);
    chk(irq, 1);
    bus(0, 4'h4, 0, q);
    chk(q, 1);
    bus(0, 4'h8, 0, q);
    chk(q, 1);
    inp <= 18'h9;
    repeat (4) @(posedge clk);
    chk(irq, 0);
    bus(0, 4'h8, 0, q);
    chk(q, 32'h4);
    bus(0, 4'h2, 0, q);
    chk(q, 0);
  endtask : irq_scn
  // Lamp test alternates neighbours; enable off then darkens the run lamp
  task test_scn;
    bus(1, 4'h0, 3, q);
    // Lamps take the test pattern one edge after the write lands
    @(posedge clk);
    pair(0, 1, 1);
    bus(1, 4'h0, 0, q);
    lampt(18'h00001, 0, 2'h0, 0);
  endtask : test_scn
  task finish_test;
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (6000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
  initial begin
    {rst, clr, rd, wr, inp, adr, sel, wd, want} = {2'h3, 2'h0, 18'h0, 4'h0, 4'h0, 32'h0, 2'h0};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(0, 4'h0, 0, q);
    chk(q, 1);
    lampt(18'h00001, 0, 2'h1, 0);
    lampt(18'h00000, 0, 2'h0, 0);
    lampt(18'h00004, 1, 2'h3, 1);
    lampt(18'h00006, 1, 2'h3, 0);
    lampt(18'h00002, 1, 2'h3, 0);
    lampt(18'h00000, 1, 2'h0, 0);
    lampt(18'h00008, 2, 2'h2, 0);
    lampt(18'h00010, 2, 2'h2, 0);
    lampt(18'h00000, 2, 2'h0, 0);
    lampt(18'h004e0, 3, 2'h0, 0);
    lampt(18'h00080, 3, 2'h0, 0);
    lampt(18'h000c0, 3, 2'h1, 0);
    lampt(18'h00140, 3, 2'h1, 1);
    lampt(18'h00240, 3, 2'h2, 1);
    lampt(18'h004c0, 3, 2'h2, 1);
    lampt(18'h00800, 4, 2'h1, 1);
    lampt(18'h01800, 4, 2'h2, 1);
    lampt(18'h02000, 5, 2'h1, 0);
    lampt(18'h04000, 5, 2'h0, 0);
    lampt(18'h04800, 6, 2'h1, 1);
    pair(4, 6, 0);
    lampt(18'h08000, 7, 2'h1, 1);
    lampt(18'h10000, 8, 2'h1, 1);
    lampt(18'h30000, 8, 2'h1, 0);
    lampt(18'h00000, 4, 2'h0, 0);
    irq_scn();
    test_scn();
    finish_test();
  end
endmodule : sid_top_tb_top
`default_nettype wire
